// file: design/sram_defs.svh
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH

// Array geometry: 512K words of 32 data bits plus 4 check bits
`define ADDR_W      19
`define DATA_W      32
`define CHK_W       4
`define LANES       4
`define LANE_BITS   8

// Burst counter covers the two lowest address bits
`define OFF_W       2

// Write commit queue depth
`define FIFO_DEPTH  16

`endif

// file: design/sram_pkg.sv
package sram_pkg;

    // Kind of beat travelling down the access pipeline
    typedef enum logic [1:0] {
        ST_NONE,
        ST_READ,
        ST_WRITE
    } stage_t;

endpackage

// file: design/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "sram_defs.svh"

// Depth must be a power of two; pointers wrap naturally
module word_fifo #(
    parameter int WIDTH = `DATA_W,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;

    wire push = i_in_valid && o_in_ready;
    wire pop  = o_out_valid && i_out_ready;

    assign o_in_ready  = count != (PTR_W + 1)'(DEPTH);
    assign o_out_valid = count != '0;
    assign o_out_data  = store[rd_ptr];

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push)
                wr_ptr <= PTR_W'(wr_ptr + 1'b1);
            if (pop)
                rd_ptr <= PTR_W'(rd_ptr + 1'b1);
            if (push && !pop)
                count <= (PTR_W + 1)'(count + 1'b1);
            else if (pop && !push)
                count <= (PTR_W + 1)'(count - 1'b1);
        end
    end

    // Storage needs no reset; only words behind valid pointers are read
    always_ff @(posedge i_core_clk) begin
        if (push)
            store[wr_ptr] <= i_in_data;
    end

endmodule // word_fifo

`default_nettype wire

// file: design/pipelined_burst_sram_access.sv
`timescale 1ns/1ps
`default_nettype none
`include "sram_defs.svh"

// Operation
// - Clock hold high freezes all state but the sleep synchronizer and the sleep clears
// - Selected edge with load low captures address
// - Write select high reads, low writes
// - Read data appears after next qualified edge
// - Drive data only while output enable low
// - New command accepted right after read
// - Deselect tristates outputs one edge later
// - Bursts of four from one address
// - Order pin low linear, high interleaved
// - Counter alters two low bits, wraps
// - Load high advances burst, ignores selects
// - Burst keeps type latched at start
// - Write start latches write; lane selects sampled on every edge
// - Edge after write forces outputs off
// - Write data captured second edge after command
// - Only selected lanes with check bit written
// - Sleep request keeps contents, low power
// - Interleaved beats XOR offset with step
// - Linear beats add step modulo four
// - Sleep entry four edges, deselect first
// - Selected when first, third low, second high
module pipelined_burst_sram_access
    import sram_pkg::*;
#(
    parameter int ADDR_W     = `ADDR_W,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_nrst,
    input  wire logic                 i_clock_hold_n,
    input  wire logic                 i_chip_sel_first_n,
    input  wire logic                 i_chip_sel_second,
    input  wire logic                 i_chip_sel_third_n,
    input  wire logic                 i_load_strobe,
    input  wire logic                 i_write_sel_n,
    input  wire logic [`LANES-1:0]    i_byte_lane_select_n,
    input  wire logic                 i_burst_order,
    input  wire logic                 i_out_enable_n,
    input  wire logic                 i_sleep_request,
    input  wire logic [ADDR_W-1:0]    i_addr,
    input  wire logic [`DATA_W-1:0]   i_data,
    output logic      [`DATA_W-1:0]   o_data,
    output logic                      o_data_oe_n,
    input  wire logic [`CHK_W-1:0]    i_check_bit_lines,
    output logic      [`CHK_W-1:0]    o_check_bit_lines,
    output logic                      o_check_bit_lines_oe_n,
    output logic                      o_sleeping,
    output logic                      o_write_backpressure
);

    localparam int WORD_W = `DATA_W + `CHK_W;
    localparam int FIFO_W = ADDR_W + `LANES + WORD_W;

    // Next burst offset: interleaved XORs the step, linear adds it
    function automatic logic [`OFF_W-1:0] burst_offset(
        input logic [`OFF_W-1:0] start,
        input logic [`OFF_W-1:0] step,
        input logic              order
    );
        burst_offset = order ? (start ^ step)
                             : `OFF_W'(start + step);
    endfunction

    // Each lane carries eight data bits and one check bit
    function automatic logic [WORD_W-1:0] lane_merge(
        input logic [WORD_W-1:0] old_word,
        input logic [WORD_W-1:0] new_word,
        input logic [`LANES-1:0] lanes_n
    );
        logic [WORD_W-1:0] res;
        res = old_word;
        for (int l = 0; l < `LANES; l++) begin
            if (!lanes_n[l]) begin
                res[l*`LANE_BITS +: `LANE_BITS] =
                    new_word[l*`LANE_BITS +: `LANE_BITS];
                res[`DATA_W + l] = new_word[`DATA_W + l];
            end
        end
        lane_merge = res;
    endfunction

    logic [WORD_W-1:0] mem [0:(2**ADDR_W)-1];

    // Sleep request is asynchronous: three stages, change once two agree
    logic sleep_ff1;
    logic sleep_ff2;
    logic sleep_ff3;
    logic sleep_state;
    // The first stage may be metastable, so only later stages are compared
    wire  sleep_agree = sleep_ff2 == sleep_ff3;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sleep_ff1   <= 1'b0;
            sleep_ff2   <= 1'b0;
            sleep_ff3   <= 1'b0;
            sleep_state <= 1'b0;
        end else begin
            sleep_ff1 <= i_sleep_request;
            sleep_ff2 <= sleep_ff1;
            sleep_ff3 <= sleep_ff2;
            if (sleep_agree)
                sleep_state <= sleep_ff3;
        end
    end

    // Burst tracking
    logic                burst_live;
    logic                burst_write;
    logic [ADDR_W-1:0]   base_addr;
    logic [`OFF_W-1:0]   start_off;
    logic [`OFF_W-1:0]   burst_step;

    // First pipeline stage: address and lanes of the beat in flight
    stage_t              s1_kind;
    logic [ADDR_W-1:0]   s1_addr;
    logic [`LANES-1:0]   s1_lanes_n;

    // Second stage: write beat waiting for its data edge
    logic                s2_write;
    logic [ADDR_W-1:0]   s2_addr;
    logic [`LANES-1:0]   s2_lanes_n;

    // Output stage
    logic                out_active;
    logic [WORD_W-1:0]   out_word;

    // Sleep blocks every edge just as clock hold does
    wire qualified = !i_clock_hold_n && !sleep_state;
    wire selected  = !i_chip_sel_first_n && i_chip_sel_second
                     && !i_chip_sel_third_n;
    wire load_cmd     = qualified && !i_load_strobe;
    wire start_cmd    = load_cmd && selected;
    wire deselect_cmd = load_cmd && !selected;
    // Chip selects and write select are not looked at here
    wire advance_cmd  = qualified && i_load_strobe && burst_live;

    // Step wraps at four, keeping the burst inside its aligned group
    wire [`OFF_W-1:0] next_step = `OFF_W'(burst_step + 1'b1);
    wire [`OFF_W-1:0] adv_off   = burst_offset(start_off, next_step,
                                               i_burst_order);
    wire [ADDR_W-1:0] adv_addr  = {base_addr[ADDR_W-1:`OFF_W],
                                   adv_off};

    wire stage_t start_kind = i_write_sel_n ? ST_READ
                                            : ST_WRITE;
    wire stage_t burst_kind = burst_write ? ST_WRITE
                                          : ST_READ;
    wire stage_t next_s1_kind = start_cmd   ? start_kind
                              : advance_cmd ? burst_kind
                              : ST_NONE;
    wire [ADDR_W-1:0] next_s1_addr = start_cmd ? i_addr : adv_addr;

    // Kind of the beat held in the first stage
    wire s1_read  = s1_kind == ST_READ;
    wire s1_write = s1_kind == ST_WRITE;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            burst_live  <= 1'b0;
            burst_write <= 1'b0;
            base_addr   <= '0;
            start_off   <= '0;
            burst_step  <= '0;
        end else if (sleep_state) begin
            // Bursts never survive sleep; the next access needs a load
            burst_live <= 1'b0;
        end else if (start_cmd) begin
            burst_live  <= 1'b1;
            burst_write <= !i_write_sel_n;
            base_addr   <= i_addr;
            start_off   <= i_addr[`OFF_W-1:0];
            burst_step  <= '0;
        end else if (deselect_cmd) begin
            burst_live <= 1'b0;
        end else if (advance_cmd) begin
            burst_step <= next_step;
        end
    end

    // Load high with no live burst is a continued deselect
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_kind    <= ST_NONE;
            s1_addr    <= '0;
            s1_lanes_n <= '1;
        end else if (sleep_state) begin
            s1_kind <= ST_NONE;
        end else if (qualified) begin
            s1_kind    <= next_s1_kind;
            s1_addr    <= next_s1_addr;
            s1_lanes_n <= i_byte_lane_select_n;
        end
    end

    // Write commit queue between the data edge and the array
    wire                push_valid;
    wire                fifo_in_ready;
    wire                fifo_out_valid;
    wire [FIFO_W-1:0]   fifo_out_data;
    wire [FIFO_W-1:0]   push_data;
    wire [WORD_W-1:0]   in_word = {i_check_bit_lines, i_data};

    // An all-lanes-off beat is a write abort and queues nothing
    wire write_abort = &s2_lanes_n;
    assign push_valid = qualified && s2_write && !write_abort;
    // Lanes travel with the word so each beat writes its own lanes
    assign push_data  = {s2_addr, s2_lanes_n, in_word};

    wire [ADDR_W-1:0]  head_addr    = fifo_out_data[FIFO_W-1 -: ADDR_W];
    wire [`LANES-1:0]  head_lanes_n = fifo_out_data[WORD_W +: `LANES];
    wire [WORD_W-1:0]  head_word    = fifo_out_data[WORD_W-1:0];
    wire               drain        = fifo_out_valid && qualified;

    word_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_commit_fifo (
        .i_core_clk  (i_core_clk),
        .i_nrst      (i_nrst),
        .i_in_valid  (push_valid),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (push_data),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (qualified),
        .o_out_data  (fifo_out_data)
    );

    // Draining halts in sleep and under clock hold so contents stay intact
    always_ff @(posedge i_core_clk) begin
        if (drain)
            mem[head_addr] <= lane_merge(mem[head_addr], head_word,
                                         head_lanes_n);
    end

    // The queue never holds more than one word, so two taps are enough
    // Reads see writes still queued or landing on this same edge
    wire               head_hit = fifo_out_valid && (head_addr == s1_addr);
    wire               inc_hit  = push_valid && (s2_addr == s1_addr);
    wire [`LANES-1:0]  head_fwd_n = head_hit ? head_lanes_n : '1;
    wire [`LANES-1:0]  inc_fwd_n  = inc_hit ? s2_lanes_n : '1;
    wire [WORD_W-1:0]  array_word = mem[s1_addr];
    wire [WORD_W-1:0]  fwd_word   = lane_merge(array_word, head_word,
                                               head_fwd_n);
    wire [WORD_W-1:0]  read_word  = lane_merge(fwd_word, in_word,
                                               inc_fwd_n);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s2_write   <= 1'b0;
            s2_addr    <= '0;
            s2_lanes_n <= '1;
        end else if (sleep_state) begin
            // Pending beats are dropped at sleep entry; the array is kept
            s2_write <= 1'b0;
        end else if (qualified) begin
            s2_write   <= s1_write;
            s2_addr    <= s1_addr;
            s2_lanes_n <= s1_lanes_n;
        end
    end

    // Output register: write beats and deselects turn the drivers off
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            out_active <= 1'b0;
            out_word   <= '0;
        end else if (sleep_state) begin
            out_active <= 1'b0;
        end else if (qualified) begin
            out_active <= s1_read;
            if (s1_read)
                out_word <= read_word;
        end
    end

    // Output enable pin is asynchronous and only gates the registered state
    wire drive_out = out_active && !sleep_state
                     && !i_out_enable_n;

    // Check lines share the data drivers, so one enable serves both
    assign o_data                 = out_word[`DATA_W-1:0];
    assign o_check_bit_lines      = out_word[WORD_W-1:`DATA_W];
    assign o_data_oe_n            = !drive_out;
    assign o_check_bit_lines_oe_n = !drive_out;
    assign o_sleeping             = sleep_state;
    // Drain keeps pace with pushes, so this rises only if the array stalls
    assign o_write_backpressure   = !fifo_in_ready;

endmodule // pipelined_burst_sram_access

`default_nettype wire

// file: dv/pipelined_burst_sram_access_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "sram_defs.svh"
module sram_access_chk (
    input wire logic               i_core_clk,
    input wire logic               i_nrst,
    input wire logic               i_clock_hold_n,
    input wire logic               i_chip_sel_first_n,
    input wire logic               i_chip_sel_second,
    input wire logic               i_chip_sel_third_n,
    input wire logic               i_load_strobe,
    input wire logic               i_write_sel_n,
    input wire logic               i_out_enable_n,
    input wire logic [`DATA_W-1:0] o_data,
    input wire logic               o_data_oe_n,
    input wire logic               o_check_bit_lines_oe_n,
    input wire logic               o_sleeping
);
    logic sel, qual, start, rd_cmd, live, rd_burst, fresh;
    assign sel = ~i_chip_sel_first_n & i_chip_sel_second & ~i_chip_sel_third_n;
    assign qual = ~i_clock_hold_n & ~o_sleeping;
    assign start = qual & sel & ~i_load_strobe;
    assign rd_cmd = start ? i_write_sel_n
                          : qual & i_load_strobe & live & rd_burst;
    // Burst state as the pins imply it; sleep drops any live burst
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            live <= 1'h0;
            rd_burst <= 1'h0;
            fresh <= 1'h1;
        end else begin
            fresh <= 1'h0;
            if (o_sleeping) live <= 1'h0;
            else if (qual & ~i_load_strobe) live <= sel;
            if (start) rd_burst <= i_write_sel_n;
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    a_hold_freeze: assert property (
        i_clock_hold_n |=> $stable(o_data)) else $error("held edge moved data");
    a_write_off: assert property (
        start & ~i_write_sel_n ##1 qual |=> o_data_oe_n)
        else $error("driving after write");
    a_read_on: assert property (
        rd_cmd ##1 qual |=> o_data_oe_n == (i_out_enable_n | o_sleeping))
        else $error("read drive wrong");
    a_desel_off: assert property (
        qual & ~i_load_strobe & ~sel ##1 qual |=> o_data_oe_n)
        else $error("driving after deselect");
    a_oe_gate: assert property (i_out_enable_n |-> o_data_oe_n)
        else $error("driving with enable high");
    a_lanes_pair: assert property (
        o_data_oe_n == o_check_bit_lines_oe_n)
        else $error("check lines drive differ");
    a_sleep_off: assert property (o_sleeping |-> o_data_oe_n)
        else $error("driving in sleep");
    a_power_off: assert property (fresh |-> o_data_oe_n)
        else $error("driving after reset");
    c_read: cover property (rd_cmd ##1 qual ##1 !o_data_oe_n);
    c_write: cover property (start & ~i_write_sel_n);
    c_sleep: cover property (o_sleeping);
endmodule // sram_access_chk
bind pipelined_burst_sram_access sram_access_chk u_chk (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_clock_hold_n(i_clock_hold_n),
    .i_chip_sel_first_n(i_chip_sel_first_n),
    .i_chip_sel_second(i_chip_sel_second),
    .i_chip_sel_third_n(i_chip_sel_third_n), .i_load_strobe(i_load_strobe),
    .i_write_sel_n(i_write_sel_n), .i_out_enable_n(i_out_enable_n),
    .o_data(o_data), .o_data_oe_n(o_data_oe_n),
    .o_check_bit_lines_oe_n(o_check_bit_lines_oe_n), .o_sleeping(o_sleeping));
`default_nettype wire

// file: dv/sram_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller data side: holds each write word two qualified edges
module sram_ctrl_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_step,
    input  wire logic        i_wr,
    input  wire logic [35:0] i_word,
    output logic             o_drive,
    output logic      [35:0] o_word
);
    logic [36:0] s1 = '0;
    logic [36:0] s2 = '0;
    logic [35:0] last = '0;
    always @(posedge i_core_clk) begin
        if (i_step) begin
            s1 <= {i_wr, i_word};
            s2 <= s1;
            if (s2[36]) last <= s2[35:0];
        end
    end
    // Off the data cycle the lines show the inverse, never a stale word
    assign o_drive = s2[36];
    assign o_word = o_drive ? s2[35:0] : ~last;
endmodule // sram_ctrl_model
`default_nettype wire

// file: dv/pipelined_burst_sram_access_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module pipelined_burst_sram_access_tb;
    logic clk = 0, nrst = 0, hold_n = 0, ld = 0, we_n = 1, order = 0;
    logic oe_pin = 0, sleep_req = 0, p_step = 0, p_wr = 0, oe_n, chk_oe_n;
    logic p_drive, sleeping, bp, live = 0, rdv = 0, exp_act = 0, btype = 0;
    logic [2:0] cs = 3'h0;
    logic [3:0] ln = 4'h0;
    logic [3:0] rchk;
    logic [5:0] addr = 6'h0, rda = 6'h0, base = 6'h0;
    logic [31:0] rdata;
    logic [35:0] p_in = '0, bus, p_word, exp, mem [64];
    logic [46:0] w1 = '0, w2 = '0;
    int n = 0, fail_count = 0, checks_done = 0, ticks = 0, i, k;
    assign bus = oe_n ? p_word : {rchk, rdata};
    pipelined_burst_sram_access #(.ADDR_W(6)) u_dut (
        .i_core_clk(clk), .i_nrst(nrst), .i_clock_hold_n(hold_n),
        .i_chip_sel_first_n(cs[2]), .i_chip_sel_second(cs[1]),
        .i_chip_sel_third_n(cs[0]), .i_load_strobe(ld), .i_write_sel_n(we_n),
        .i_byte_lane_select_n(ln), .i_burst_order(order),
        .i_out_enable_n(oe_pin), .i_sleep_request(sleep_req), .i_addr(addr),
        .i_data(bus[31:0]), .o_data(rdata), .o_data_oe_n(oe_n),
        .i_check_bit_lines(bus[35:32]), .o_check_bit_lines(rchk),
        .o_check_bit_lines_oe_n(chk_oe_n), .o_sleeping(sleeping),
        .o_write_backpressure(bp));
    sram_ctrl_model u_ctrl (.i_core_clk(clk), .i_step(p_step), .i_wr(p_wr),
        .i_word(p_in), .o_drive(p_drive), .o_word(p_word));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        ticks++;
        if (ticks == 3000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic summarize();
        if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cyc(input logic [2:0] c, input logic h, l, w,
                       input logic [3:0] b, input logic [5:0] a);
        logic q, st, bv;
        logic [1:0] off;
        logic [5:0] ba, wa;
        {cs, hold_n, ld, we_n, ln, addr} = {c, h, l, w, b, a};
        oe_pin = ($urandom_range(3) == 0);
        p_in = 36'({$urandom, $urandom});
        q = !h && !sleeping;
        st = q && c == 3'h2 && !l;
        if (st) {btype, base} = {w, a};
        if (q && !l) live = st;
        if (q) n = l ? n + 1 : 0;
        off = order ? base[1:0] ^ n[1:0]
                    : base[1:0] + n[1:0];
        ba = {base[5:2], off};
        bv = q && live;
        {p_step, p_wr} = {q, bv && !btype};
        @(posedge clk);
        #1;
        if (q) begin
            wa = w2[45:40];
            for (int j = 0; j < 4; j++)
                if (w2[46] && !w2[36+j]) begin
                    mem[wa][32+j] = w2[32+j];
                    mem[wa][8*j+:8] = w2[8*j+:8];
                end
            exp_act = rdv;
            exp = mem[rda];
            w2 = w1;
            w1 = {bv && !btype, ba, b, p_in};
            {rdv, rda} = {bv && btype, ba};
        end
        if (exp_act) begin
            `CHK(rdata, exp[31:0])
            `CHK(rchk, exp[35:32])
        end
        `CHK(oe_n, !exp_act || oe_pin)
        `CHK(chk_oe_n, !exp_act || oe_pin)
        `CHK(p_drive && !oe_n, 1'h0)
        `CHK(bp, 1'h0)
    endtask
    task automatic rnd(input logic h, l);
        cyc($urandom_range(1) ? 3'h2 : 3'($urandom), h, l, 1'($urandom),
            4'($urandom), 6'($urandom));
    endtask
    initial begin
        void'($urandom(25039));
        repeat (4) @(posedge clk);
        #1;
        nrst = 1;
        for (i = 0; i < 64; i++) cyc(3'h2, 0, 0, 0, 4'h0, 6'(i));
        // Every start offset, both orders, one advance past the wrap
        for (i = 0; i < 16; i++) begin
            order = i[2];
            cyc(3'h2, 0, 0, !i[3], 4'h0, 6'(i * 9));
            repeat (4) rnd(0, 1);
        end
        for (i = 0; i < 4; i++) cyc(3'h2, 0, 0, i != 1, 4'h5, 6'h7);
        repeat (400) rnd($urandom_range(3) == 0, 1'($urandom));
        // Deselect before sleep; commands while asleep must be dropped
        sleep_req = 1;
        repeat (6) cyc(3'h0, 0, 0, 1, 4'h0, 6'h0);
        repeat (3) cyc(3'h2, 0, 0, 1, 4'h0, 6'h1);
        `CHK(sleeping, 1'h1)
        sleep_req = 0;
        repeat (6) cyc(3'h0, 0, 0, 1, 4'h0, 6'h0);
        `CHK(sleeping, 1'h0)
        repeat (20) rnd(0, 1'($urandom));
        // Let queued writes land before the reset clears the queue
        repeat (2) cyc(3'h0, 0, 0, 1, 4'h0, 6'h0);
        cyc(3'h2, 0, 0, 1, 4'h0, 6'h3);
        cyc(3'h0, 0, 1, 1, 4'h0, 6'h0);
        nrst = 0;
        #3;
        `CHK(oe_n, 1'h1)
        {live, rdv, exp_act, w1, w2} = '0;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1;
        repeat (20) rnd(0, 1'($urandom));
        // Holds split each write from its data edge; reads right behind
        // it must see the word while queued or landing
        for (k = 0; k < 16; k++) begin
            cyc(3'h2, 0, 0, 0, 4'($urandom), 6'(k * 4 + 2));
            cyc(3'h2, 1, 0, 1, 4'h0, 6'h0);
            cyc(3'h2, 0, 0, 1, 4'h0, 6'(k * 4 + 2));
            cyc(3'h2, 1, 1, 0, 4'h0, 6'h0);
            cyc(3'h2, 0, 0, 1, 4'h0, 6'(k * 4 + 2));
        end
        repeat (2) cyc(3'h0, 0, 0, 1, 4'h0, 6'h0);
        `CHK(oe_n, 1'h1)
        `CHK(bp, 1'h0)
        `CHK(sleeping, 1'h0)
        summarize();
    end
endmodule // pipelined_burst_sram_access_tb
`default_nettype wire
